// >>> src/bcdt_ctrl.sv
`timescale 1ns/1ps
// How it works
// (R1) Bits 15 to 12 read zero, writes ignored.
// (R2) Bit 11 set: primary discard timeout raises system error pulse.
// (R3) Bit 10 sets when either discard timer expires and discards.
// (R4) Bit 10 clears only by writing one; writing zero keeps it.
// (R5) Bit 9 picks secondary timer: 0 is 2^15 clocks, 1 is 2^10.
// (R6) Bit 8 picks primary timer: 0 is 2^15 clocks, 1 is 2^10.
// (R7) Masters must repeat retried requests within the timer period.
// (R8) Bit 7 reads zero; no fast back-to-back to different targets.
// (R9) Bit 6 set holds the secondary bus reset output asserted.
// (R10) Timer runs from target completion until master takes completion.
module bcdt_ctrl
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire bcdt_pkg::bcdt_cfg_t cfg,
	input wire bcdt_pkg::bcdt_dly_t pri_dly,
	input wire bcdt_pkg::bcdt_dly_t sec_dly,
	output logic [15:0] rdata,
	output logic pri_discard,
	output logic sec_discard,
	output logic serr_req,
	output logic sec_rst_n,
	output logic fbb_en
);
	logic serr_en_q, serr_en_d;
	logic status_q, status_d;
	logic sec_sel_q, sec_sel_d;
	logic pri_sel_q, pri_sel_d;
	logic sec_rst_q, sec_rst_d;
	logic [15:0] pri_cnt_q, pri_cnt_d, sec_cnt_q, sec_cnt_d;
	logic pri_run_q, pri_run_d, sec_run_q, sec_run_d;
	logic pri_exp, sec_exp;
	logic [15:0] rdata_d;
	logic hit_wr_hi, hit_rd;

	// Timer length from selection bit
	function automatic logic [15:0] dt_len(input logic short_sel);
		dt_len = short_sel ? bcdt_pkg::DT_SHORT_CYC : bcdt_pkg::DT_LONG_CYC;
	endfunction

	// Address decode
	always_comb
	begin
		hit_wr_hi = 1'b0;
		hit_rd = 1'b0;
		if (cfg.addr == bcdt_pkg::SSC_OFFSET)
		begin
			hit_wr_hi = cfg.wr && cfg.be[1];
			hit_rd = cfg.rd;
		end
	end

	// Timer expiry on last counted clock
	assign pri_exp = pri_run_q && !pri_dly.taken && (pri_cnt_q == 16'h0001);
	assign sec_exp = sec_run_q && !sec_dly.taken && (sec_cnt_q == 16'h0001);

	// Register bits and discard timers next state
	always_comb
	begin
		serr_en_d = serr_en_q;
		sec_sel_d = sec_sel_q;
		pri_sel_d = pri_sel_q;
		sec_rst_d = sec_rst_q;
		status_d = status_q;
		if (hit_wr_hi)
		begin
			serr_en_d = cfg.wdata[bcdt_pkg::DT_SERR_EN_BIT]; // [R2]
			sec_sel_d = cfg.wdata[bcdt_pkg::SEC_DT_SEL_BIT]; // [R5]
			pri_sel_d = cfg.wdata[bcdt_pkg::PRI_DT_SEL_BIT]; // [R6]
			if (cfg.wdata[bcdt_pkg::DT_STATUS_BIT])
				status_d = 1'b0; // [R4]
		end
		if (cfg.wr && cfg.be[0] && cfg.addr == bcdt_pkg::SSC_OFFSET)
			sec_rst_d = cfg.wdata[bcdt_pkg::SEC_RST_BIT]; // [R9]
		if (pri_exp || sec_exp)
			status_d = 1'b1; // Set beats clear [R3]
		// Primary timer [R10]
		pri_run_d = pri_run_q;
		pri_cnt_d = pri_cnt_q;
		if (pri_dly.taken || pri_exp)
			pri_run_d = 1'b0;
		else if (pri_dly.done)
		begin
			pri_run_d = 1'b1;
			pri_cnt_d = dt_len(pri_sel_q); // [R6]
		end
		else if (pri_run_q)
			pri_cnt_d = pri_cnt_q - 16'h0001;
		// Secondary timer [R10]
		sec_run_d = sec_run_q;
		sec_cnt_d = sec_cnt_q;
		if (sec_dly.taken || sec_exp)
			sec_run_d = 1'b0;
		else if (sec_dly.done)
		begin
			sec_run_d = 1'b1;
			sec_cnt_d = dt_len(sec_sel_q); // [R5]
		end
		else if (sec_run_q)
			sec_cnt_d = sec_cnt_q - 16'h0001;
		// Read image, fixed bits zero [R1] [R8]
		rdata_d = 16'h0000;
		if (hit_rd)
		begin
			rdata_d[bcdt_pkg::DT_SERR_EN_BIT] = serr_en_q;
			rdata_d[bcdt_pkg::DT_STATUS_BIT] = status_q;
			rdata_d[bcdt_pkg::SEC_DT_SEL_BIT] = sec_sel_q;
			rdata_d[bcdt_pkg::PRI_DT_SEL_BIT] = pri_sel_q;
			rdata_d[bcdt_pkg::SEC_RST_BIT] = sec_rst_q;
		end
	end

	// State registers
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			serr_en_q <= 1'b0;
			status_q <= 1'b0;
			sec_sel_q <= 1'b0;
			pri_sel_q <= 1'b0;
			sec_rst_q <= 1'b0;
			pri_run_q <= 1'b0;
			sec_run_q <= 1'b0;
			pri_cnt_q <= 16'h0000;
			sec_cnt_q <= 16'h0000;
			rdata <= 16'h0000;
			pri_discard <= 1'b0;
			sec_discard <= 1'b0;
			serr_req <= 1'b0;
			sec_rst_n <= 1'b1;
			fbb_en <= 1'b0;
		end
		else
		begin
			serr_en_q <= serr_en_d;
			status_q <= status_d;
			sec_sel_q <= sec_sel_d;
			pri_sel_q <= pri_sel_d;
			sec_rst_q <= sec_rst_d;
			pri_run_q <= pri_run_d;
			sec_run_q <= sec_run_d;
			pri_cnt_q <= pri_cnt_d;
			sec_cnt_q <= sec_cnt_d;
			rdata <= rdata_d;
			pri_discard <= pri_exp; // [R3]
			sec_discard <= sec_exp; // [R3]
			serr_req <= pri_exp && serr_en_q; // [R2]
			sec_rst_n <= !sec_rst_d; // [R9]
			fbb_en <= 1'b0; // [R8]
		end
	end

	// Assertions
	// Last counted clock of each discard timer
	sequence pri_last_clk;
		pri_run_q && !pri_dly.taken && pri_cnt_q == 16'h0001;
	endsequence
	sequence sec_last_clk;
		sec_run_q && !sec_dly.taken && sec_cnt_q == 16'h0001;
	endsequence
	// Software writes one to the status bit
	sequence status_wr_one;
		hit_wr_hi && cfg.wdata[bcdt_pkg::DT_STATUS_BIT];
	endsequence

	// Fixed bits read zero
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn) // [R1] [R8]
		rdata[15:12] == 4'h0 && !rdata[bcdt_pkg::FBB_BIT])
		else $error("fixed bits nonzero");
	// System error only on primary discard with enable set
	a_serr_gate: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
		serr_req |-> pri_discard && $past(serr_en_q))
		else $error("bad serr");
	a_serr_quiet: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
		!serr_en_q |=> !serr_req)
		else $error("serr while disabled");
	a_serr_raise: assert property (@(posedge ref_clk) disable iff (!resetn) // [R2]
		pri_last_clk ##0 serr_en_q |=> serr_req)
		else $error("serr missing");
	// Status sets on expiry and clears only by a write of one
	a_status_set: assert property (@(posedge ref_clk) disable iff (!resetn) // [R3]
		(pri_exp || sec_exp) |=> status_q)
		else $error("status not set");
	a_status_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
		status_q && !(hit_wr_hi && cfg.wdata[bcdt_pkg::DT_STATUS_BIT]) |=> status_q)
		else $error("status lost");
	a_status_clear: assert property (@(posedge ref_clk) disable iff (!resetn) // [R4]
		status_q && !pri_exp && !sec_exp ##0 status_wr_one |=> !status_q)
		else $error("status not cleared");
	// Timer lengths follow the selection bits
	a_sec_load: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
		sec_dly.done && !sec_dly.taken && !sec_exp
		|=> sec_cnt_q == dt_len($past(sec_sel_q))) else $error("sec length");
	a_pri_load: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
		pri_dly.done && !pri_dly.taken && !pri_exp
		|=> pri_cnt_q == dt_len($past(pri_sel_q))) else $error("pri length");
	// One count per clock while a timer runs
	a_sec_count: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
		sec_run_q && !sec_dly.done && !sec_dly.taken && !sec_exp
		|=> sec_cnt_q == $past(sec_cnt_q) - 16'h0001) else $error("sec count");
	a_pri_count: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
		pri_run_q && !pri_dly.done && !pri_dly.taken && !pri_exp
		|=> pri_cnt_q == $past(pri_cnt_q) - 16'h0001) else $error("pri count");
	// Discard pulse right after the last counted clock
	a_sec_discard: assert property (@(posedge ref_clk) disable iff (!resetn) // [R5]
		sec_last_clk |=> sec_discard && !sec_run_q)
		else $error("sec discard missing");
	a_pri_discard: assert property (@(posedge ref_clk) disable iff (!resetn) // [R6]
		pri_last_clk |=> pri_discard && !pri_run_q)
		else $error("pri discard missing");
	// Fast back-to-back never offered
	a_fbb_off: assert property (@(posedge ref_clk) disable iff (!resetn) // [R8]
		!fbb_en)
		else $error("fbb on");
	// Secondary bus reset follows bit 6
	a_sec_reset: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
		sec_rst_q |-> !sec_rst_n)
		else $error("sec reset released");
	a_sec_release: assert property (@(posedge ref_clk) disable iff (!resetn) // [R9]
		!sec_rst_q |-> sec_rst_n)
		else $error("sec reset stuck");
	// Completion taken stops the timer with no discard
	a_timer_stop: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
		pri_dly.taken |=> !pri_run_q ##1 !pri_discard)
		else $error("timer ran on");
	a_sec_stop: assert property (@(posedge ref_clk) disable iff (!resetn) // [R10]
		sec_dly.taken |=> !sec_run_q ##1 !sec_discard)
		else $error("sec timer ran on");
endmodule

// >>> common/bcdt_pkg.sv
package bcdt_pkg;
	// Register location in configuration space (16-bit register)
	localparam logic [7:0] SSC_OFFSET = 8'h3e;
	localparam logic [15:0] SSC_RESET = 16'h0000;
	// Field positions
	localparam int DT_SERR_EN_BIT = 11;
	localparam int DT_STATUS_BIT = 10;
	localparam int SEC_DT_SEL_BIT = 9;
	localparam int PRI_DT_SEL_BIT = 8;
	localparam int FBB_BIT = 7;
	localparam int SEC_RST_BIT = 6;
	// Discard timer lengths in clocks
	localparam int DT_LONG_LOG2 = 15;
	localparam int DT_SHORT_LOG2 = 10;
	localparam int DT_WIDTH = 16;
	localparam logic [15:0] DT_LONG_CYC = 16'h8000;
	localparam logic [15:0] DT_SHORT_CYC = 16'h0400;

	// Configuration access to the register
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} bcdt_cfg_t;

	// Delayed transaction events for one interface
	typedef struct packed
	{
		logic done;
		logic taken;
	} bcdt_dly_t;
endpackage

// >>> tb/bcdt_master_model.sv
`timescale 1ns/1ps
// Master that gets retried, then repeats its request after gap clocks (0: never)
module bcdt_master_model
(
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [15:0] gap,
	output bcdt_pkg::bcdt_dly_t dly
);
	logic [15:0] cnt = 16'h0;
	logic [15:0] cnt_d;
	bcdt_pkg::bcdt_dly_t dly_d;
	initial dly = '0;
	// Completion on the target side, then the repeat
	always @(posedge ref_clk)
	begin
		dly_d = '0;
		cnt_d = (cnt != 16'h0) ? cnt - 16'h1 : 16'h0;
		if (go)
		begin
			dly_d.done = 1'b1;
			cnt_d = gap;
		end
		else if (cnt == 16'h1)
			dly_d.taken = 1'b1;
		dly <= dly_d;
		cnt <= cnt_d;
	end
endmodule

// >>> tb/bridge_control_discard_timers_tb_top.sv
`timescale 1ns/1ps
module bridge_control_discard_timers_tb_top;
	logic ref_clk = 0;
	logic resetn = 0;
	bcdt_pkg::bcdt_cfg_t cfg = '0;
	logic pg = 0, sg = 0, pdis, sdis, serr, srst_n, fbb;
	logic [15:0] gap = 16'h0, rdata, sh = 16'h0, d;
	bcdt_pkg::bcdt_dly_t pd, sd;
	int fail_count = 0, tests_run = 0, c;
	logic [7:0] a;
	logic [1:0] b;
	always #20 ref_clk = ~ref_clk;
	bcdt_master_model pri_u (.ref_clk(ref_clk), .go(pg), .gap(gap), .dly(pd));
	bcdt_master_model sec_u (.ref_clk(ref_clk), .go(sg), .gap(gap), .dly(sd));
	bcdt_ctrl dut_u (.ref_clk(ref_clk), .resetn(resetn), .cfg(cfg), .pri_dly(pd), .sec_dly(sd),
		.rdata(rdata), .pri_discard(pdis), .sec_discard(sdis), .serr_req(serr),
		.sec_rst_n(srst_n), .fbb_en(fbb));
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One configuration cycle, strobe held for one clock
	task acc(input logic w, input logic [7:0] ad, input logic [1:0] be, input logic [15:0] wd);
		@(posedge ref_clk);
		cfg <= {w, ~w, ad, be, wd};
		@(posedge ref_clk);
		cfg <= '0;
		#1;
	endtask
	function automatic logic [15:0] nxt(logic [15:0] o, logic [1:0] be, logic [15:0] w);
		logic [15:0] r;
		r = o;
		if (be[1])
			r[11:8] = {w[11], o[10] & ~w[10], w[9:8]};
		if (be[0])
			r[6] = w[6];
		return r;
	endfunction
	// Start a delayed transaction and count clocks to the discard
	task run(input logic s, input logic [15:0] g, input int lim);
		@(posedge ref_clk);
		{sg, pg, gap} <= {s, ~s, g};
		@(posedge ref_clk);
		{sg, pg} <= 2'b00;
		#1;
		c = 0;
		while (!(s ? sdis : pdis) && c < lim)
		begin
			@(posedge ref_clk);
			#1;
			c++;
		end
	endtask
	initial
	begin
		c = $urandom(98912);
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		acc(0, 8'h3e, 2'h3, 16'h0);
		chk(rdata, 16'h0, "reset value");
		repeat (40)
		begin
			d = 16'($urandom);
			a = ($urandom % 2) ? 8'h3e : 8'h3c;
			b = 2'($urandom);
			acc(1, a, b, d);
			if (a == 8'h3e)
				sh = nxt(sh, b, d);
			chk({15'h0, srst_n}, {15'h0, ~sh[6]}, "secondary reset");
			acc(0, a, 2'h3, 16'h0);
			chk(rdata, (a == 8'h3e) ? sh : 16'h0, "readback");
			chk({15'h0, fbb}, 16'h0, "fast b2b");
		end
		acc(1, 8'h3e, 2'h3, 16'h0b00);
		run(0, 16'h0, 1200);
		chk({15'h0, c >= 1023 && c <= 1030}, 16'h1, "short primary");
		chk({15'h0, serr}, 16'h1, "serr enabled");
		acc(1, 8'h3e, 2'h2, 16'h0b00);
		acc(0, 8'h3e, 2'h3, 16'h0);
		chk(rdata, 16'h0f00, "status sticky");
		acc(1, 8'h3e, 2'h2, 16'h0f00);
		acc(0, 8'h3e, 2'h3, 16'h0);
		chk(rdata, 16'h0b00, "status cleared");
		run(0, 16'd500, 1200);
		chk({15'h0, c == 1200}, 16'h1, "repeat in time");
		acc(1, 8'h3e, 2'h2, 16'h0900);
		run(1, 16'h0, 33000);
		chk({15'h0, c >= 32767 && c <= 32774}, 16'h1, "long secondary");
		chk({15'h0, serr}, 16'h0, "no serr secondary");
		acc(0, 8'h3e, 2'h3, 16'h0);
		chk(rdata, 16'h0d00, "secondary status");
		// Long primary timer with system error disabled
		acc(1, 8'h3e, 2'h2, 16'h0400);
		run(0, 16'h0, 33000);
		chk({15'h0, c >= 32767 && c <= 32774}, 16'h1, "long primary");
		chk({15'h0, serr}, 16'h0, "serr disabled");
		acc(0, 8'h3e, 2'h3, 16'h0);
		chk(rdata, 16'h0400, "primary status");
		// Forced secondary reset, then a controller reset while it is held
		acc(1, 8'h3e, 2'h3, 16'h0b40);
		chk({15'h0, srst_n}, 16'h0, "reset forced");
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		#1;
		chk({15'h0, srst_n}, 16'h1, "reset released");
		acc(0, 8'h3e, 2'h3, 16'h0);
		chk(rdata, 16'h0, "value after reset");
		close_out();
	end
endmodule
